// ### dv/i2c_slave_model.sv
// Behavioural I2C slave: acks one address, logs writes, streams reads
`timescale 1ns/1ns
module i2c_slave_model #(
	parameter logic [6:0] DEV_ADDR = 7'h50
) (
	input wire logic i_scl, // Bus clock level
	input wire logic i_sda, // Bus data level
	input wire logic [7:0] i_rd_base, // First byte returned on reads
	output logic o_sda_low, // Pulls data low when set
	output logic [7:0] o_rx_last, // Last byte written to the slave
	output int o_rx_cnt, // Bytes written so far
	output int o_rd_cnt, // Bytes read in the last transfer
	output int o_starts // START conditions seen
);
	int bitn = 9;
	int k = 0;
	logic [7:0] sh = 8'h00;
	logic [7:0] txb = 8'h00;
	logic adr = 1'b0;
	logic sel = 1'b0;
	logic rd = 1'b0;
	initial begin
		o_sda_low = 1'b0;
		o_rx_last = 8'h00;
		o_rx_cnt = 0;
		o_rd_cnt = 0;
		o_starts = 0;
	end
	// START or repeated START opens an address phase
	always @(negedge i_sda) begin
		if (i_scl === 1'b1) begin
			bitn = 0;
			adr = 1'b1;
			sel = 1'b0;
			o_starts++;
		end
	end
	// STOP frees the bus
	always @(posedge i_sda) begin
		if (i_scl === 1'b1) begin
			sel = 1'b0;
			adr = 1'b0;
		end
	end
	always @(posedge i_scl) begin
		if (bitn < 8) begin
			sh = {sh[6:0], i_sda};
		end else if (bitn == 8 && sel && rd && !adr) begin
			o_rd_cnt++;
			if (i_sda) sel = 1'b0;
		end
		bitn++;
	end
	always @(negedge i_scl) begin
		o_sda_low = 1'b0;
		if (bitn == 8 && adr) begin
			sel = (sh[7:1] == DEV_ADDR);
			rd = sh[0];
			o_sda_low = sel;
			o_rd_cnt = 0;
			k = 0;
		end else if (bitn == 8 && sel && !rd) begin
			o_rx_last = sh;
			o_rx_cnt++;
			o_sda_low = 1'b1;
		end else if (bitn == 9) begin
			bitn = 0;
			adr = 1'b0;
			txb = i_rd_base + 8'(k);
			k++;
		end
		if (sel && rd && !adr && bitn < 8) o_sda_low = !txb[7 - bitn];
	end
endmodule : i2c_slave_model

// ### dv/tb_i2c_master_controller.sv
// Self-checking bench for the I2C master controller
`timescale 1ns/1ns
module tb_i2c_master_controller;
	localparam logic [6:0] DEV = 7'h50;
	logic i_mclk = 1'b0;
	logic i_rst_n = 1'b0;
	logic [9:0] i_awaddr = 10'h000;
	logic [9:0] i_araddr = 10'h000;
	logic [31:0] i_wdata = 32'h0;
	logic [3:0] i_wstrb = 4'hf;
	logic i_awvalid = 1'b0;
	logic i_wvalid = 1'b0;
	logic i_bready = 1'b0;
	logic i_arvalid = 1'b0;
	logic i_rready = 1'b0;
	logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
	logic [1:0] o_bresp, o_rresp;
	logic [31:0] o_rdata;
	i2c_pkg::pins_t i_pin, o_pin_o, o_pin_oe_n, i_spi_o, i_spi_oe_n;
	logic sda_low;
	logic [7:0] rd_base = 8'h00;
	logic [7:0] b, v;
	logic [7:0] exq[$];
	logic [7:0] rxq[$];
	int rx_cnt, rd_cnt, starts, c, n, k, s, scl_per;
	int n_errors = 0;
	int cmp_count = 0;
	time scl_t = 0;

	always #4 i_mclk = ~i_mclk;
	assign i_pin = {o_pin_oe_n.scl | o_pin_o.scl,
		(o_pin_oe_n.sda | o_pin_o.sda) & ~sda_low};
	// Byte is read inside the model, where it is settled before the count
	always @(rx_cnt) rxq.push_back(slave.o_rx_last);
	always @(posedge i_pin.scl) begin
		scl_per = int'($time - scl_t) / 8;
		scl_t = $time;
	end

	i2c_master_controller dut (.i_mclk, .i_rst_n, .i_awaddr, .i_awvalid,
		.o_awready, .i_wdata, .i_wstrb, .i_wvalid, .o_wready, .o_bresp,
		.o_bvalid, .i_bready, .i_araddr, .i_arvalid, .o_arready, .o_rdata,
		.o_rresp, .o_rvalid, .i_rready, .i_pin, .o_pin_o, .o_pin_oe_n,
		.i_spi_o, .i_spi_oe_n);
	i2c_slave_model #(.DEV_ADDR(DEV)) slave (.i_scl(i_pin.scl),
		.i_sda(i_pin.sda), .i_rd_base(rd_base), .o_sda_low(sda_low),
		.o_rx_last(), .o_rx_cnt(rx_cnt), .o_rd_cnt(rd_cnt),
		.o_starts(starts));

	// ----------------------------------------
	// Bus tasks and checks
	// ----------------------------------------
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic wr(input logic [7:0] idx, input logic [7:0] d,
		input logic [1:0] er = i2c_pkg::RESP_OKAY);
		int t = 0;
		@(posedge i_mclk);
		i_awaddr <= {idx, 2'b00};
		i_wdata <= {24'h0, d};
		i_awvalid <= 1'b1;
		i_wvalid <= 1'b1;
		i_bready <= 1'b1;
		do @(posedge i_mclk); while (o_awready !== 1'b1 && ++t < 50);
		i_awvalid <= 1'b0;
		i_wvalid <= 1'b0;
		while (o_bvalid !== 1'b1 && ++t < 50) @(posedge i_mclk);
		i_bready <= 1'b0;
		chk("bvalid", 1'b1, o_bvalid);
		chk("bresp", er, o_bresp);
	endtask : wr

	task automatic rd(input logic [7:0] idx, output logic [7:0] d,
		input logic [1:0] er = i2c_pkg::RESP_OKAY);
		int t = 0;
		@(posedge i_mclk);
		i_araddr <= {idx, 2'b00};
		i_arvalid <= 1'b1;
		i_rready <= 1'b1;
		do @(posedge i_mclk); while (o_arready !== 1'b1 && ++t < 50);
		i_arvalid <= 1'b0;
		while (o_rvalid !== 1'b1 && ++t < 50) @(posedge i_mclk);
		i_rready <= 1'b0;
		d = o_rdata[7:0];
		chk("rvalid", 1'b1, o_rvalid);
		chk("rresp", er, o_rresp);
		chk("rdata_hi", 24'h0, o_rdata[31:8]);
	endtask : rd

	task automatic rdc(input string nm, input logic [7:0] idx,
		input logic [7:0] e);
		logic [7:0] g;
		rd(idx, g);
		chk(nm, e, g);
	endtask : rdc

	task automatic wait_idle();
		logic [7:0] g;
		repeat (3000) begin
			rd(i2c_pkg::IDX_STAT, g);
			if (g[7] === 1'b0) break;
		end
		chk("idle", 1'b0, g[7]);
	endtask : wait_idle

	function automatic logic [1:0] fill(input int m);
		return (m == 4) ? i2c_pkg::FILL_FULL : i2c_pkg::FILL_HALF;
	endfunction : fill

	task automatic print_verdict();
		if (n_errors == 0 && cmp_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : print_verdict

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		#(8 * 90000);
		n_errors++;
		print_verdict();
	end

	initial begin
		void'($urandom(32'h975d7316));
		i_spi_o = 2'($urandom);
		i_spi_oe_n = 2'b11;
		repeat (20) @(posedge i_mclk);
		i_rst_n <= 1'b1;
		rdc("mode", i2c_pkg::IDX_MODE, 8'h00);
		rdc("addr", i2c_pkg::IDX_ADDR, 8'h00);
		rdc("stat", i2c_pkg::IDX_STAT, 8'h10);
		rdc("rx", i2c_pkg::IDX_RX, 8'h00);
		rd(8'h00, v, i2c_pkg::RESP_SLVERR);
		wr(8'h01, 8'h5a, i2c_pkg::RESP_SLVERR);
		for (c = 0; c < 4; c++) begin
			n = (c == 0) ? 4 : 1 + $urandom % 4;
			exq.delete();
			rxq.delete();
			for (k = 0; k < n; k++) begin
				b = 8'($urandom);
				exq.push_back(b);
				wr(i2c_pkg::IDX_TX, b);
			end
			if (n == 4) wr(i2c_pkg::IDX_TX, 8'hee);
			rdc("stat_pre", i2c_pkg::IDX_STAT, {4'h1, fill(n), 1'b0, n == 4});
			wr(i2c_pkg::IDX_STAT, 8'h00);
			rdc("stat_clr", i2c_pkg::IDX_STAT, {4'h0, fill(n), 2'h0});
			wr(i2c_pkg::IDX_MODE, {1'b1, c[1:0], 5'h00});
			wr(i2c_pkg::IDX_ADDR, {DEV, 1'b0});
			wait_idle();
			rdc("stat_end", i2c_pkg::IDX_STAT, 8'h10);
			chk("wr_bytes", n, rxq.size());
			for (k = 0; k < n; k++) chk("wr_data", exq[k], rxq[k]);
			chk("scl_period", 16 << c, scl_per);
		end
		chk("pin_o", 2'b00, o_pin_o);
		for (c = 0; c < 4; c++) begin
			n = (c == 3) ? 4 : 1 + $urandom % 4;
			b = 8'($urandom);
			rd_base <= b;
			wr(i2c_pkg::IDX_MODE, {1'b1, c[1:0], 5'(n - 1)});
			wr(i2c_pkg::IDX_ADDR, {DEV, 1'b1});
			wait_idle();
			chk("rd_bytes", n, rd_cnt);
			rdc("stat_rd", i2c_pkg::IDX_STAT, {4'h3, fill(n), 2'h0});
			for (k = 0; k < n; k++) rdc("rx", i2c_pkg::IDX_RX, 8'(b + k));
			rdc("rx_empty", i2c_pkg::IDX_RX, 8'h00);
			chk("scl_period", 16 << c, scl_per);
			wr(i2c_pkg::IDX_STAT, 8'h00);
		end
		// Address rewrite during the address byte: repeated START, then read
		wr(i2c_pkg::IDX_MODE, 8'h80);
		wr(i2c_pkg::IDX_TX, 8'h5a);
		s = starts;
		wr(i2c_pkg::IDX_ADDR, {DEV, 1'b0});
		repeat (40) @(posedge i_mclk);
		wr(i2c_pkg::IDX_ADDR, {DEV, 1'b1});
		wait_idle();
		chk("restarts", s + 2, starts);
		chk("rs_bytes", 1, rd_cnt);
		rdc("stat_rs", i2c_pkg::IDX_STAT, 8'h38);
		rdc("rs_rx", i2c_pkg::IDX_RX, b);
		wr(i2c_pkg::IDX_STAT, 8'h80);
		wr(i2c_pkg::IDX_MODE, 8'h80);
		wr(i2c_pkg::IDX_TX, 8'h3c);
		wr(i2c_pkg::IDX_TX, 8'hc3);
		wr(i2c_pkg::IDX_ADDR, {DEV ^ 7'h01, 1'b0});
		wait_idle();
		rdc("stat_nack", i2c_pkg::IDX_STAT, 8'h50);
		wr(i2c_pkg::IDX_STAT, 8'h00);
		rdc("stat_nclr", i2c_pkg::IDX_STAT, 8'h10);
		s = starts;
		wr(i2c_pkg::IDX_MODE, 8'h00);
		wr(i2c_pkg::IDX_TX, 8'h11);
		wr(i2c_pkg::IDX_ADDR, {DEV, 1'b0});
		repeat (40) @(posedge i_mclk);
		rdc("stat_off", i2c_pkg::IDX_STAT, 8'h18);
		chk("starts", s, starts);
		wr(i2c_pkg::IDX_STAT, 8'h80);
		rdc("stat_flush", i2c_pkg::IDX_STAT, 8'h10);
		fork
			wr(i2c_pkg::IDX_MODE, 8'h00);
			rd(i2c_pkg::IDX_ADDR, v);
		join
		rdc("stat_acc", i2c_pkg::IDX_STAT, 8'h12);
		wr(i2c_pkg::IDX_STAT, 8'h00);
		wr(i2c_pkg::IDX_PINSEL, 8'h01);
		i_spi_oe_n <= 2'($urandom);
		repeat (3) @(posedge i_mclk);
		chk("pin_oe", i_spi_oe_n, o_pin_oe_n);
		chk("pin_o_spi", i_spi_o, o_pin_o);
		print_verdict();
	end
endmodule : tb_i2c_master_controller

// ### logic/i2c_master_controller.sv
// I2C bus master with AXI4-Lite register access and shared pins
// Operation
// - pin select routes pins to I2C or SPI
// - SDA and SCL are open-drain wired-AND
// - start only on idle bus, then address
// - data only after address ack; STOP ends
// - SCL is core clock over 16 times 2^code
// - address write launches transfer when enabled
// - address bits 7-1, bit 0 read direction
// - write takes transmit data, read fills receive
// - mode bit 7 enables the master
// - read stops after count plus one bytes
// - busy flag; writing it flushes transmit FIFO
// - missing ack sets flag and stops
// - receive flag set while receive FIFO holds data
// - transmit flag set while transmit FIFO empty
// - fill level of the active FIFO
// - simultaneous read and write sets error
// - write to full transmit FIFO sets error
// - registers shared with SPI at same indices
// - auto ack on reads, NACK on last byte
// - four-entry receive and transmit FIFOs
// - empty transmit FIFO stops; NACK in a write flushes it
// - address rewrite mid-transfer gives repeated START
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ns
module i2c_master_controller #(
	parameter int FIFO_DEPTH = i2c_pkg::FIFO_DEPTH
) (
	input wire logic i_mclk, // Core clock, 125 MHz
	input wire logic i_rst_n, // Asynchronous reset, active low
	input wire logic [i2c_pkg::ADDR_W-1:0] i_awaddr, // Write address
	input wire logic i_awvalid, // Write address valid
	output logic o_awready, // Write address ready
	input wire logic [i2c_pkg::DATA_W-1:0] i_wdata, // Write data
	input wire logic [3:0] i_wstrb, // Write strobes
	input wire logic i_wvalid, // Write data valid
	output logic o_wready, // Write data ready
	output logic [1:0] o_bresp, // Write response
	output logic o_bvalid, // Write response valid
	input wire logic i_bready, // Write response ready
	input wire logic [i2c_pkg::ADDR_W-1:0] i_araddr, // Read address
	input wire logic i_arvalid, // Read address valid
	output logic o_arready, // Read address ready
	output logic [i2c_pkg::DATA_W-1:0] o_rdata, // Read data
	output logic [1:0] o_rresp, // Read response
	output logic o_rvalid, // Read data valid
	input wire logic i_rready, // Read data ready
	input wire i2c_pkg::pins_t i_pin, // Pin levels seen on the wires
	output i2c_pkg::pins_t o_pin_o, // Pin output values
	output i2c_pkg::pins_t o_pin_oe_n, // Pin enables, low drives
	input wire i2c_pkg::pins_t i_spi_o, // SPI pin output values
	input wire i2c_pkg::pins_t i_spi_oe_n // SPI pin enables, low drives
);
	localparam int PW = $clog2(FIFO_DEPTH);
	localparam int FTX = 0;
	localparam int FRX = 1;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [1:0] fill_code(input logic [PW:0] c);
		if (c == '0) begin
			return i2c_pkg::FILL_EMPTY;
		end
		if (c == (PW+1)'(FIFO_DEPTH)) begin
			return i2c_pkg::FILL_FULL;
		end
		return i2c_pkg::FILL_HALF;
	endfunction : fill_code

	function automatic logic clears(input logic sel, input logic wbit);
		return sel & ~wbit;
	endfunction : clears

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	i2c_pkg::eng_state_t st_reg;
	logic aw_rdy_reg, ar_rdy_reg, bvalid_reg, rvalid_reg;
	logic [1:0] bresp_reg, rresp_reg;
	logic [31:0] rdata_reg;
	logic [7:0] mode_reg, addr_reg;
	logic pinsel_reg;
	logic noack_reg, rxirq_reg, txirq_reg, acc_reg, ovf_reg;
	logic pend_reg, rs_reg, is_addr_reg, rd_reg, ack_reg;
	logic [4:0] rem_reg;
	logic [7:0] shift_reg, qcnt_reg;
	logic [1:0] phase_reg;
	logic [3:0] bit_reg;
	logic bus_busy_reg;
	i2c_pkg::pins_t pin_d_reg, pin_o_reg, pin_oe_n_reg;
	logic [1:0] f_push, f_pop, f_flush;
	logic [7:0] f_din [2];
	logic [7:0] f_dout [2];
	logic [PW:0] f_cnt [2];

	// ------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------
	wire [7:0] widx = i_awaddr[9:2];
	wire [7:0] ridx = i_araddr[9:2];
	wire wr_go = i_awvalid & i_wvalid & ~aw_rdy_reg & ~bvalid_reg;
	wire rd_go = i_arvalid & ~ar_rdy_reg & ~rvalid_reg;
	wire wr_en = aw_rdy_reg & i_wstrb[0];
	wire rd_en = ar_rdy_reg;
	wire wr_tx = wr_en & (widx == i2c_pkg::IDX_TX);
	wire wr_mode = wr_en & (widx == i2c_pkg::IDX_MODE);
	wire wr_addr = wr_en & (widx == i2c_pkg::IDX_ADDR);
	wire wr_stat = wr_en & (widx == i2c_pkg::IDX_STAT);
	wire wr_psel = wr_en & (widx == i2c_pkg::IDX_PINSEL);
	wire w_hit = (widx == i2c_pkg::IDX_TX) | (widx == i2c_pkg::IDX_RX)
		| (widx == i2c_pkg::IDX_MODE) | (widx == i2c_pkg::IDX_ADDR)
		| (widx == i2c_pkg::IDX_STAT) | (widx == i2c_pkg::IDX_PINSEL);
	wire rd_rx = rd_en & (ridx == i2c_pkg::IDX_RX);
	wire [7:0] wd = i_wdata[7:0];

	// ------------------------------------------------------------
	// Engine decode
	// ------------------------------------------------------------
	wire en = mode_reg[i2c_pkg::MODE_EN_BIT];
	wire sel_spi = pinsel_reg;
	wire run = st_reg != i2c_pkg::ST_IDLE;
	wire [1:0] div = mode_reg[i2c_pkg::MODE_DIV_LSB +: 2];
	wire [7:0] qlen = i2c_pkg::QUARTER_BASE << div;
	wire tick = run & (qcnt_reg == qlen - 8'h01);
	wire ph_end = tick & (phase_reg == 2'd3);
	wire samp = tick & (phase_reg == 2'd1);
	wire in_byte = st_reg == i2c_pkg::ST_BYTE;
	wire byte_end = ph_end & in_byte & (bit_reg == 4'd8);
	wire rx_byte = ~is_addr_reg & rd_reg;
	wire tx_nack = byte_end & ~rx_byte & ack_reg;
	wire last_rx = rem_reg == 5'd0;
	wire tx_has = f_cnt[FTX] != '0;
	wire launch = (st_reg == i2c_pkg::ST_IDLE) & pend_reg & en & ~sel_spi
		& ~bus_busy_reg;
	wire ack_drv = ~last_rx & ~pend_reg;
	wire tx_bit = (bit_reg == 4'd8) ? 1'b1 : shift_reg[7];
	wire rx_bit = (bit_reg == 4'd8) ? ~ack_drv : 1'b1;
	wire sda_lvl = rx_byte ? rx_bit : tx_bit;
	logic scl_lo, sda_lo;
	always_comb begin
		scl_lo = 1'b0;
		sda_lo = 1'b0;
		unique case (st_reg)
			i2c_pkg::ST_IDLE: begin
				scl_lo = 1'b0;
				sda_lo = 1'b0;
			end
			i2c_pkg::ST_START: begin
				scl_lo = ((phase_reg == 2'd0) & rs_reg) | (phase_reg == 2'd3);
				sda_lo = phase_reg[1];
			end
			i2c_pkg::ST_BYTE: begin
				scl_lo = (phase_reg == 2'd0) | (phase_reg == 2'd3);
				sda_lo = ~sda_lvl;
			end
			i2c_pkg::ST_STOP: begin
				scl_lo = phase_reg == 2'd0;
				sda_lo = phase_reg != 2'd3;
			end
		endcase
	end

	// ------------------------------------------------------------
	// FIFOs
	// ------------------------------------------------------------
	assign f_push[FTX] = wr_tx & (f_cnt[FTX] != (PW+1)'(FIFO_DEPTH));
	assign f_pop[FTX] = byte_end & ~ack_reg & ~rd_reg & ~pend_reg & tx_has;
	assign f_flush[FTX] = (wr_stat & wd[i2c_pkg::STAT_BUSY_BIT])
		| (tx_nack & ~rd_reg);
	assign f_din[FTX] = wd;
	assign f_push[FRX] = byte_end & rx_byte
		& (f_cnt[FRX] != (PW+1)'(FIFO_DEPTH));
	assign f_pop[FRX] = rd_rx & (f_cnt[FRX] != '0);
	assign f_flush[FRX] = 1'b0;
	assign f_din[FRX] = shift_reg;

	generate
		for (genvar g = 0; g < 2; g++) begin : g_fifo
			logic [7:0] mem [FIFO_DEPTH];
			logic [PW-1:0] wp_reg, rp_reg;
			logic [PW:0] cnt_reg;
			assign f_dout[g] = mem[rp_reg];
			assign f_cnt[g] = cnt_reg;
			always_ff @(posedge i_mclk) begin
				if (f_push[g]) begin
					mem[wp_reg] <= f_din[g];
				end
			end
			always_ff @(posedge i_mclk or negedge i_rst_n) begin
				if (!i_rst_n) begin
					wp_reg <= '0;
					rp_reg <= '0;
					cnt_reg <= '0;
				end else if (f_flush[g]) begin
					wp_reg <= '0;
					rp_reg <= '0;
					cnt_reg <= '0;
				end else begin
					wp_reg <= wp_reg + PW'(f_push[g]);
					rp_reg <= rp_reg + PW'(f_pop[g]);
					cnt_reg <= cnt_reg + (PW+1)'(f_push[g])
						- (PW+1)'(f_pop[g]);
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// Register read path
	// ------------------------------------------------------------
	wire act_rx = run ? rd_reg : addr_reg[i2c_pkg::DIR_BIT];
	wire [1:0] fill = fill_code(act_rx ? f_cnt[FRX] : f_cnt[FTX]);
	wire [7:0] stat_rd = {run | pend_reg, noack_reg, rxirq_reg,
		txirq_reg, fill, acc_reg, ovf_reg};
	wire [7:0] rxd = (f_cnt[FRX] != '0) ? f_dout[FRX]
		: i2c_pkg::RXDATA_RST;
	logic [7:0] rd_mux;
	logic rd_hit;
	always_comb begin
		rd_hit = 1'b1;
		unique case (ridx)
			i2c_pkg::IDX_TX: rd_mux = 8'h00;
			i2c_pkg::IDX_RX: rd_mux = rxd;
			i2c_pkg::IDX_MODE: rd_mux = mode_reg;
			i2c_pkg::IDX_ADDR: rd_mux = addr_reg;
			i2c_pkg::IDX_STAT: rd_mux = stat_rd;
			i2c_pkg::IDX_PINSEL: rd_mux = {7'h00, pinsel_reg};
			default: begin
				rd_mux = 8'h00;
				rd_hit = 1'b0;
			end
		endcase
	end

	// ------------------------------------------------------------
	// AXI4-Lite handshakes
	// ------------------------------------------------------------
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			aw_rdy_reg <= 1'b0;
			ar_rdy_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			rvalid_reg <= 1'b0;
			bresp_reg <= i2c_pkg::RESP_OKAY;
			rresp_reg <= i2c_pkg::RESP_OKAY;
			rdata_reg <= 32'h0000_0000;
		end else begin
			aw_rdy_reg <= wr_go;
			ar_rdy_reg <= rd_go;
			if (aw_rdy_reg) begin
				bvalid_reg <= 1'b1;
				bresp_reg <= w_hit ? i2c_pkg::RESP_OKAY
					: i2c_pkg::RESP_SLVERR;
			end else if (i_bready) begin
				bvalid_reg <= 1'b0;
			end
			if (rd_en) begin
				rvalid_reg <= 1'b1;
				rdata_reg <= {24'h000000, rd_mux};
				rresp_reg <= rd_hit ? i2c_pkg::RESP_OKAY
					: i2c_pkg::RESP_SLVERR;
			end else if (i_rready) begin
				rvalid_reg <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// Software registers and flags
	// ------------------------------------------------------------
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			mode_reg <= i2c_pkg::MODE_RST;
			addr_reg <= i2c_pkg::ADDR_RST;
			pinsel_reg <= i2c_pkg::PINSEL_RST;
			noack_reg <= i2c_pkg::FLAG_RST;
			rxirq_reg <= i2c_pkg::FLAG_RST;
			txirq_reg <= i2c_pkg::FLAG_RST;
			acc_reg <= i2c_pkg::FLAG_RST;
			ovf_reg <= i2c_pkg::FLAG_RST;
		end else begin
			if (wr_mode) begin
				mode_reg <= wd;
			end
			if (wr_addr) begin
				addr_reg <= wd;
			end
			if (wr_psel) begin
				pinsel_reg <= wd[i2c_pkg::PINSEL_BIT];
			end
			noack_reg <= tx_nack | (noack_reg
				& ~clears(wr_stat, wd[i2c_pkg::STAT_NOACK_BIT]));
			rxirq_reg <= (f_cnt[FRX] != '0) | (rxirq_reg
				& ~clears(wr_stat, wd[i2c_pkg::STAT_RXIRQ_BIT]));
			txirq_reg <= (f_cnt[FTX] == '0) | (txirq_reg
				& ~clears(wr_stat, wd[i2c_pkg::STAT_TXIRQ_BIT]));
			acc_reg <= (wr_en & rd_en) | (acc_reg
				& ~clears(wr_stat, wd[i2c_pkg::STAT_ACC_BIT]));
			ovf_reg <= (wr_tx & ~f_push[FTX]) | (ovf_reg
				& ~clears(wr_stat, wd[i2c_pkg::STAT_OVF_BIT]));
		end
	end

	// ------------------------------------------------------------
	// Bit timing and bus monitor
	// ------------------------------------------------------------
	wire bus_start = pin_d_reg.scl & i_pin.scl & pin_d_reg.sda & ~i_pin.sda;
	wire bus_stop = pin_d_reg.scl & i_pin.scl & ~pin_d_reg.sda & i_pin.sda;
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			qcnt_reg <= 8'h00;
			phase_reg <= 2'd0;
			pin_d_reg <= 2'b11;
			bus_busy_reg <= 1'b0;
		end else begin
			qcnt_reg <= (!run || tick) ? 8'h00 : qcnt_reg + 8'h01;
			phase_reg <= !run ? 2'd0 : phase_reg + 2'(tick);
			pin_d_reg <= i_pin;
			if (bus_start) begin
				bus_busy_reg <= 1'b1;
			end else if (bus_stop) begin
				bus_busy_reg <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// Transfer engine
	// ------------------------------------------------------------
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_reg <= i2c_pkg::ST_IDLE;
			pend_reg <= 1'b0;
			rs_reg <= 1'b0;
			is_addr_reg <= 1'b0;
			rd_reg <= 1'b0;
			ack_reg <= 1'b0;
			rem_reg <= 5'd0;
			shift_reg <= 8'h00;
			bit_reg <= 4'd0;
		end else begin
			if (wr_addr & en) begin
				pend_reg <= 1'b1;
			end else if (st_reg == i2c_pkg::ST_START && ph_end) begin
				pend_reg <= 1'b0;
			end
			if (samp && in_byte) begin
				if (bit_reg == 4'd8) begin
					ack_reg <= i_pin.sda;
				end else if (rx_byte) begin
					shift_reg <= {shift_reg[6:0], i_pin.sda};
				end
			end
			if (ph_end && in_byte && bit_reg != 4'd8) begin
				bit_reg <= bit_reg + 4'd1;
				if (!rx_byte) begin
					shift_reg <= {shift_reg[6:0], 1'b0};
				end
			end
			unique case (st_reg)
				i2c_pkg::ST_IDLE: begin
					if (launch) begin
						st_reg <= i2c_pkg::ST_START;
						rs_reg <= 1'b0;
					end
				end
				i2c_pkg::ST_START: begin
					if (ph_end) begin
						st_reg <= i2c_pkg::ST_BYTE;
						shift_reg <= addr_reg;
						is_addr_reg <= 1'b1;
						rd_reg <= addr_reg[i2c_pkg::DIR_BIT];
						rem_reg <= mode_reg[i2c_pkg::MODE_CNT_MSB:0];
						bit_reg <= 4'd0;
					end
				end
				i2c_pkg::ST_BYTE: begin
					if (byte_end) begin
						bit_reg <= 4'd0;
						is_addr_reg <= 1'b0;
						if (ack_reg && !rx_byte) begin
							st_reg <= i2c_pkg::ST_STOP;
						end else if (pend_reg) begin
							st_reg <= i2c_pkg::ST_START;
							rs_reg <= 1'b1;
						end else if (rx_byte) begin
							if (last_rx) begin
								st_reg <= i2c_pkg::ST_STOP;
							end else begin
								rem_reg <= rem_reg - 5'd1;
							end
						end else if (!rd_reg) begin
							if (tx_has) begin
								shift_reg <= f_dout[FTX];
							end else begin
								st_reg <= i2c_pkg::ST_STOP;
							end
						end
					end
				end
				i2c_pkg::ST_STOP: begin
					if (ph_end) begin
						st_reg <= i2c_pkg::ST_IDLE;
					end
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Pin drivers
	// ------------------------------------------------------------
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pin_o_reg <= 2'b00;
			pin_oe_n_reg <= 2'b11;
		end else begin
			pin_o_reg <= sel_spi ? i_spi_o : 2'b00;
			pin_oe_n_reg <= sel_spi ? i_spi_oe_n : {~scl_lo, ~sda_lo};
		end
	end

	assign o_awready = aw_rdy_reg;
	assign o_wready = aw_rdy_reg;
	assign o_bvalid = bvalid_reg;
	assign o_bresp = bresp_reg;
	assign o_arready = ar_rdy_reg;
	assign o_rvalid = rvalid_reg;
	assign o_rdata = rdata_reg;
	assign o_rresp = rresp_reg;
	assign o_pin_o = pin_o_reg;
	assign o_pin_oe_n = pin_oe_n_reg;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rst_n);

	property p_quarter;
		tick |=> !tick [*3];
	endproperty
	a_quarter: assert property (p_quarter) else $error("quarter short");

	property p_enable;
		wr_addr && !en && !pend_reg |=> !pend_reg;
	endproperty
	a_enable: assert property (p_enable) else $error("start w/o enable");

	property p_idle_start;
		st_reg == i2c_pkg::ST_IDLE ##1 st_reg == i2c_pkg::ST_START
			|-> $past(!bus_busy_reg);
	endproperty
	a_idle_start: assert property (p_idle_start) else $error("busy start");

	property p_nack;
		tx_nack |=> st_reg == i2c_pkg::ST_STOP && noack_reg;
	endproperty
	a_nack: assert property (p_nack) else $error("nack not handled");

	property p_ovf;
		wr_tx && f_cnt[FTX] == (PW+1)'(FIFO_DEPTH) |=> ovf_reg;
	endproperty
	a_ovf: assert property (p_ovf) else $error("overfill missed");

	property p_acc;
		wr_en && rd_en |=> acc_reg;
	endproperty
	a_acc: assert property (p_acc) else $error("collision missed");

	property p_rxirq;
		f_cnt[FRX] != '0 |=> rxirq_reg;
	endproperty
	a_rxirq: assert property (p_rxirq) else $error("rx flag low");

	property p_txirq;
		f_cnt[FTX] == '0 |=> txirq_reg;
	endproperty
	a_txirq: assert property (p_txirq) else $error("tx flag low");

	property p_open_drain;
		!sel_spi ##1 1 |-> o_pin_o == 2'b00;
	endproperty
	a_open_drain: assert property (p_open_drain) else $error("drives high");

	property p_flush;
		wr_stat && wd[i2c_pkg::STAT_BUSY_BIT] |=> f_cnt[FTX] == '0;
	endproperty
	a_flush: assert property (p_flush) else $error("no flush");
endmodule : i2c_master_controller

// ### logic/i2c_pkg.sv
// Shared constants and types for the I2C master controller
package i2c_pkg;
	localparam int ADDR_W = 10;
	localparam int DATA_W = 32;
	localparam int FIFO_DEPTH = 4;

	// Register indices; the byte address is four times the index
	localparam logic [7:0] IDX_TX = 8'h9a;
	localparam logic [7:0] IDX_RX = 8'h9b;
	localparam logic [7:0] IDX_MODE = 8'he8;
	localparam logic [7:0] IDX_ADDR = 8'he9;
	localparam logic [7:0] IDX_STAT = 8'hea;
	localparam logic [7:0] IDX_PINSEL = 8'heb;

	// Reset values
	localparam logic [7:0] MODE_RST = 8'h00;
	localparam logic [7:0] ADDR_RST = 8'h00;
	localparam logic [7:0] RXDATA_RST = 8'h00;
	localparam logic PINSEL_RST = 1'b0;
	localparam logic FLAG_RST = 1'b0;

	// Field positions
	localparam int MODE_EN_BIT = 7;
	localparam int MODE_DIV_LSB = 5;
	localparam int MODE_CNT_MSB = 4;
	localparam int DIR_BIT = 0;
	localparam int STAT_BUSY_BIT = 7;
	localparam int STAT_NOACK_BIT = 6;
	localparam int STAT_RXIRQ_BIT = 5;
	localparam int STAT_TXIRQ_BIT = 4;
	localparam int STAT_ACC_BIT = 1;
	localparam int STAT_OVF_BIT = 0;
	localparam int PINSEL_BIT = 0;

	localparam logic [1:0] FILL_EMPTY = 2'h0;
	localparam logic [1:0] FILL_HALF = 2'h2;
	localparam logic [1:0] FILL_FULL = 2'h3;

	// Clocks per quarter bit at divider code 00 (16 per bit)
	localparam logic [7:0] QUARTER_BASE = 8'h04;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_START = 2'b01,
		ST_BYTE = 2'b10,
		ST_STOP = 2'b11
	} eng_state_t;

	typedef struct packed {
		logic scl;
		logic sda;
	} pins_t;
endpackage : i2c_pkg
